// [pkg/irq_pkg.sv]
// package: register map, bit positions and vector numbering of the interrupt request logic
package irq_pkg;
  // register byte addresses on apb (printed offsets for the second enable and request flags)
  localparam logic [11:0] ADDR_IEN_FIRST = 12'h0A8;
  localparam logic [11:0] ADDR_IEN_SECOND = 12'h0B8;
  localparam logic [11:0] ADDR_REQ_FLAGS = 12'h0C0;
  localparam logic [11:0] ADDR_TIMER_CONTROL_AND_EXT_IRQ = 12'h088;
  localparam logic [11:0] ADDR_TIMER2_CONTROL = 12'h0C8;
  localparam logic [11:0] ADDR_PRIO_LOW = 12'h0A9;
  localparam logic [11:0] ADDR_PRIO_HIGH = 12'h0B9;
  localparam logic [11:0] ADDR_MISC = 12'h0D0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // first enable register fields
  localparam int EN_GLOBAL = 7;
  localparam int EN_T2 = 5;
  localparam int EN_SER = 4;
  localparam int EN_T1 = 3;
  localparam int EN_X1 = 2;
  localparam int EN_T0 = 1;
  localparam int EN_X0 = 0;
  // second enable register fields
  localparam int EN_T2RLD = 7;
  localparam int EN_X6 = 5;
  localparam int EN_X5 = 4;
  localparam int EN_X4 = 3;
  localparam int EN_X3 = 2;
  localparam int EN_BUS = 1;
  localparam int EN_CONV = 0;
  // request flag register fields
  localparam int RQ_T2RLD = 7;
  localparam int RQ_T2OVF = 6;
  localparam int RQ_X6 = 5;
  localparam int RQ_X5 = 4;
  localparam int RQ_X4 = 3;
  localparam int RQ_X3 = 2;
  localparam int RQ_SWI = 1;
  localparam int RQ_CONV = 0;
  // timer control fields
  localparam int TC_TF1 = 7;
  localparam int TC_TF0 = 5;
  localparam int TC_IE1 = 3;
  localparam int TC_IT1 = 2;
  localparam int TC_IE0 = 1;
  localparam int TC_IT0 = 0;
  localparam int T2_POL3 = 6;
  // vector numbering, polling order from highest natural priority
  localparam int NVEC = 12;
  localparam int NGRP = 6;
  localparam int V_X0 = 0;
  localparam int V_CONV = 1;
  localparam int V_T0 = 2;
  localparam int V_BUS = 3;
  localparam int V_X1 = 4;
  localparam int V_X3 = 5;
  localparam int V_T1 = 6;
  localparam int V_X4 = 7;
  localparam int V_SER = 8;
  localparam int V_X5 = 9;
  localparam int V_T2 = 10;
  localparam int V_X6 = 11;
  // machine cycle of twelve clocks; flags sampled on phase SAMPLE_PHASE
  localparam int MC_CLOCKS = 12;
  localparam logic [3:0] MC_LAST = 4'(MC_CLOCKS - 1);
  localparam logic [3:0] SAMPLE_PHASE = 4'h9;
endpackage : irq_pkg

// [pkg/irq_edge_if.sv]
// interface: synchronised pin level and detected edges between detector and controller
`timescale 1ns/10ps
interface irq_edge_if;
  logic [5:0] level;
  logic [5:0] fall;
  logic [5:0] rise;
  modport det (output level, output fall, output rise);
  modport ctl (input level, input fall, input rise);
endinterface : irq_edge_if

// [core/irq_pin_sync.sv]
// module: two-stage synchronisers and edge detection for the six external interrupt pins
`timescale 1ns/10ps
module irq_pin_sync (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [5:0] pins,
  irq_edge_if.det edges
);
  typedef struct packed {
    logic [5:0] meta;
    logic [5:0] sync;
    logic [5:0] prev;
    logic [5:0] fall;
    logic [5:0] rise;
  } irq_sync_t;
  irq_sync_t s_q;
  irq_sync_t s_d;
  always_comb
  begin
    s_d = s_q;
    s_d.meta = pins;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    // first differing sampled level sets the edge strobe
    s_d.fall = s_q.prev & ~s_q.sync;
    s_d.rise = ~s_q.prev & s_q.sync;
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    // pins idle high so reset does not fake a falling edge
    if (!nrst)
      s_q <= '{meta: 6'h3F, sync: 6'h3F, prev: 6'h3F, fall: 6'h00, rise: 6'h00};
    else
      s_q <= s_d;
  end
  assign edges.level = s_q.sync;
  assign edges.fall = s_q.fall;
  assign edges.rise = s_q.rise;
endmodule : irq_pin_sync

// [core/irq_ack_select.sv]
// module: priority resolver picking the winning pending vector
`timescale 1ns/10ps
module irq_ack_select (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [11:0] pending,
  input wire logic [5:0] prioLow,
  input wire logic [5:0] prioHigh,
  output logic valid,
  output logic [3:0] vector,
  output logic [1:0] level
);
  typedef struct packed {
    logic valid;
    logic [3:0] vector;
    logic [1:0] level;
  } irq_sel_t;
  irq_sel_t s_q;
  irq_sel_t s_d;
  function automatic logic [1:0] grpLevel(input logic [5:0] lo, input logic [5:0] hi, input int g);
    grpLevel = {hi[g], lo[g]};
  endfunction : grpLevel
  always_comb
  begin
    logic [1:0] lv;
    lv = 2'h0;
    s_d = '0;
    // higher index polled first; greater-or-equal lets the later, lower index win equal levels
    for (int v = irq_pkg::NVEC - 1; v >= 0; v--)
    begin
      lv = grpLevel(prioLow, prioHigh, v / 2);
      if (pending[v] && (!s_d.valid || lv >= s_d.level))
      begin
        s_d.valid = 1'b1;
        s_d.vector = 4'(v);
        s_d.level = lv;
      end
    end
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign valid = s_q.valid;
  assign vector = s_q.vector;
  assign level = s_q.level;
endmodule : irq_ack_select

// [core/irq_request_ctrl.sv]
// module: interrupt request flags, enables, triggering and apb register file
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
// Contract
// - twelve vectors, each with four priority levels
// - bus-controller and software interrupt share vector
// - timer 2 compare events raise ext 3-6
// - global enable low blocks every request
// - all enable bits reset to zero
// - each vector gated by own enable
// - reload enable gates interrupt only, not reload
// - software interrupt needs bus-controller enable
// - timer 0/1 overflow flags cleared on vectoring
// - ext 0/1 select low level or falling edge
// - ext 0/1 edge flags cleared; level tracks pin
// - ext 3 polarity selects falling or rising
// - compare event sets ext 3 flag
// - ext 3 flag cleared on vectoring
// - power-down exit on low pulse, two pins
// - timer 2 request ORs overflow and reload
// - ext 4-6 rising edge, cleared on vectoring
// - two priority bits per group, both highest
// - flags sampled once per machine cycle
module irq_request_ctrl (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] extPins,
  input wire logic alternateReceivePin,
  input wire logic timer0Overflow,
  input wire logic timer1Overflow,
  input wire logic timer2Overflow,
  input wire logic timer2ReloadEdge,
  input wire logic [3:0] compareEvent,
  input wire logic serialIrq,
  input wire logic converterDone,
  input wire logic busCtrlIrq,
  input wire logic powerDown,
  input wire logic vectorAck,
  input wire logic [3:0] vectorAckNum,
  output logic irqValid,
  output logic [3:0] irqVector,
  output logic [1:0] irqLevel,
  output logic [11:0] irqRequest,
  output logic timer2Reload,
  output logic wakeUp
);
  typedef struct packed {
    logic [7:0] ienFirst;
    logic [7:0] ienSecond;
    logic [7:0] reqFlags;
    logic [7:0] timer_control_and_ext_irq;
    logic [7:0] timer2_control;
    logic [5:0] prioLow;
    logic [5:0] prioHigh;
    logic [11:0] sampled;
    logic [11:0] request;
    logic [3:0] phase;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic reload;
    logic wake;
    logic [1:0] wakeSync;
    logic [1:0] wakeMeta;
  } irq_ctrl_t;
  irq_ctrl_t s_q;
  irq_ctrl_t s_d;
  irq_edge_if edges ();
  logic selValid;
  logic [3:0] selVector;
  logic [1:0] selLevel;
  irq_pin_sync u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pins(extPins),
    .edges(edges)
  );
  irq_ack_select u_sel (
    .mclk(mclk),
    .nrst(nrst),
    .pending(s_q.request),
    .prioLow(s_q.prioLow),
    .prioHigh(s_q.prioHigh),
    .valid(selValid),
    .vector(selVector),
    .level(selLevel)
  );
  function automatic logic ackOf(input logic ack, input logic [3:0] num, input int v);
    ackOf = ack && (num == 4'(v));
  endfunction : ackOf
  // raw flag of every vector before enabling
  logic [11:0] rawFlag;
  logic [11:0] vecEn;
  always_comb
  begin
    rawFlag = '0;
    vecEn = '0;
    rawFlag[irq_pkg::V_X0] = s_q.timer_control_and_ext_irq[irq_pkg::TC_IE0];
    rawFlag[irq_pkg::V_CONV] = s_q.reqFlags[irq_pkg::RQ_CONV];
    rawFlag[irq_pkg::V_T0] = s_q.timer_control_and_ext_irq[irq_pkg::TC_TF0];
    // either source reaches the one shared entry
    rawFlag[irq_pkg::V_BUS] = s_q.reqFlags[irq_pkg::RQ_SWI] | busCtrlIrq;
    rawFlag[irq_pkg::V_X1] = s_q.timer_control_and_ext_irq[irq_pkg::TC_IE1];
    rawFlag[irq_pkg::V_X3] = s_q.reqFlags[irq_pkg::RQ_X3];
    rawFlag[irq_pkg::V_T1] = s_q.timer_control_and_ext_irq[irq_pkg::TC_TF1];
    rawFlag[irq_pkg::V_X4] = s_q.reqFlags[irq_pkg::RQ_X4];
    rawFlag[irq_pkg::V_SER] = serialIrq;
    rawFlag[irq_pkg::V_X5] = s_q.reqFlags[irq_pkg::RQ_X5];
    // overflow or reload, the reload half gated by its own enable
    rawFlag[irq_pkg::V_T2] = s_q.timer2_control[7] |
      (s_q.reqFlags[irq_pkg::RQ_T2RLD] & s_q.ienSecond[irq_pkg::EN_T2RLD]);
    rawFlag[irq_pkg::V_X6] = s_q.reqFlags[irq_pkg::RQ_X6];
    vecEn[irq_pkg::V_X0] = s_q.ienFirst[irq_pkg::EN_X0];
    vecEn[irq_pkg::V_CONV] = s_q.ienSecond[irq_pkg::EN_CONV];
    vecEn[irq_pkg::V_T0] = s_q.ienFirst[irq_pkg::EN_T0];
    vecEn[irq_pkg::V_BUS] = s_q.ienSecond[irq_pkg::EN_BUS];
    vecEn[irq_pkg::V_X1] = s_q.ienFirst[irq_pkg::EN_X1];
    vecEn[irq_pkg::V_X3] = s_q.ienSecond[irq_pkg::EN_X3];
    vecEn[irq_pkg::V_T1] = s_q.ienFirst[irq_pkg::EN_T1];
    vecEn[irq_pkg::V_X4] = s_q.ienSecond[irq_pkg::EN_X4];
    vecEn[irq_pkg::V_SER] = s_q.ienFirst[irq_pkg::EN_SER];
    vecEn[irq_pkg::V_X5] = s_q.ienSecond[irq_pkg::EN_X5];
    vecEn[irq_pkg::V_T2] = s_q.ienFirst[irq_pkg::EN_T2];
    vecEn[irq_pkg::V_X6] = s_q.ienSecond[irq_pkg::EN_X6];
  end

  logic apbWr;
  logic apbRd;
  logic [7:0] wb;
  assign apbWr = psel && penable && pwrite && s_q.ready;
  assign apbRd = psel && !penable && !pwrite;
  assign wb = pwdata[7:0];

  always_comb
  begin
    s_d = s_q;
    // one wait state: ready rises in the access phase, falls after it
    s_d.ready = psel && !s_q.ready && penable;
    s_d.slverr = 1'b0;
    s_d.reload = timer2ReloadEdge;
    // software writes first, hardware events override so a set is never lost
    if (apbWr)
    begin
      case (paddr)
        irq_pkg::ADDR_IEN_FIRST: s_d.ienFirst = wb;
        irq_pkg::ADDR_IEN_SECOND: s_d.ienSecond = wb;
        irq_pkg::ADDR_REQ_FLAGS: s_d.reqFlags = wb;
        irq_pkg::ADDR_TIMER_CONTROL_AND_EXT_IRQ:
        begin
          s_d.timer_control_and_ext_irq = wb;
          // in level mode writes cannot touch the request flag
          if (!s_q.timer_control_and_ext_irq[irq_pkg::TC_IT0])
            s_d.timer_control_and_ext_irq[irq_pkg::TC_IE0] = s_q.timer_control_and_ext_irq[irq_pkg::TC_IE0];
          if (!s_q.timer_control_and_ext_irq[irq_pkg::TC_IT1])
            s_d.timer_control_and_ext_irq[irq_pkg::TC_IE1] = s_q.timer_control_and_ext_irq[irq_pkg::TC_IE1];
        end
        irq_pkg::ADDR_TIMER2_CONTROL: s_d.timer2_control = wb;
        irq_pkg::ADDR_PRIO_LOW: s_d.prioLow = wb[5:0];
        irq_pkg::ADDR_PRIO_HIGH: s_d.prioHigh = wb[5:0];
        irq_pkg::ADDR_MISC: ;
        default: ;
      endcase
    end
    // decided in the first access cycle so the error stands with ready
    if (psel && penable && !s_q.ready)
      s_d.slverr = !(paddr inside {irq_pkg::ADDR_IEN_FIRST, irq_pkg::ADDR_IEN_SECOND,
        irq_pkg::ADDR_REQ_FLAGS, irq_pkg::ADDR_TIMER_CONTROL_AND_EXT_IRQ, irq_pkg::ADDR_TIMER2_CONTROL,
        irq_pkg::ADDR_PRIO_LOW, irq_pkg::ADDR_PRIO_HIGH, irq_pkg::ADDR_MISC});
    // clears on vectoring, only for the self-clearing flags
    if (ackOf(vectorAck, vectorAckNum, irq_pkg::V_T0))
      s_d.timer_control_and_ext_irq[irq_pkg::TC_TF0] = 1'b0;
    if (ackOf(vectorAck, vectorAckNum, irq_pkg::V_T1))
      s_d.timer_control_and_ext_irq[irq_pkg::TC_TF1] = 1'b0;
    if (ackOf(vectorAck, vectorAckNum, irq_pkg::V_X0) && s_q.timer_control_and_ext_irq[irq_pkg::TC_IT0])
      s_d.timer_control_and_ext_irq[irq_pkg::TC_IE0] = 1'b0;
    if (ackOf(vectorAck, vectorAckNum, irq_pkg::V_X1) && s_q.timer_control_and_ext_irq[irq_pkg::TC_IT1])
      s_d.timer_control_and_ext_irq[irq_pkg::TC_IE1] = 1'b0;
    if (ackOf(vectorAck, vectorAckNum, irq_pkg::V_X3))
      s_d.reqFlags[irq_pkg::RQ_X3] = 1'b0;
    if (ackOf(vectorAck, vectorAckNum, irq_pkg::V_X4))
      s_d.reqFlags[irq_pkg::RQ_X4] = 1'b0;
    if (ackOf(vectorAck, vectorAckNum, irq_pkg::V_X5))
      s_d.reqFlags[irq_pkg::RQ_X5] = 1'b0;
    if (ackOf(vectorAck, vectorAckNum, irq_pkg::V_X6))
      s_d.reqFlags[irq_pkg::RQ_X6] = 1'b0;
    if (ackOf(vectorAck, vectorAckNum, irq_pkg::V_BUS))
      s_d.reqFlags[irq_pkg::RQ_SWI] = 1'b0;
    // hardware sets win over any clear in the same cycle
    if (timer0Overflow)
      s_d.timer_control_and_ext_irq[irq_pkg::TC_TF0] = 1'b1;
    if (timer1Overflow)
      s_d.timer_control_and_ext_irq[irq_pkg::TC_TF1] = 1'b1;
    if (timer2Overflow)
      s_d.timer2_control[7] = 1'b1;
    if (timer2ReloadEdge)
      s_d.reqFlags[irq_pkg::RQ_T2RLD] = 1'b1;
    if (converterDone)
      s_d.reqFlags[irq_pkg::RQ_CONV] = 1'b1;
    // ext 0/1: level mode tracks the low pin, edge mode latches a fall
    if (!s_q.timer_control_and_ext_irq[irq_pkg::TC_IT0])
      s_d.timer_control_and_ext_irq[irq_pkg::TC_IE0] = !edges.level[0];
    else if (edges.fall[0])
      s_d.timer_control_and_ext_irq[irq_pkg::TC_IE0] = 1'b1;
    if (!s_q.timer_control_and_ext_irq[irq_pkg::TC_IT1])
      s_d.timer_control_and_ext_irq[irq_pkg::TC_IE1] = !edges.level[1];
    else if (edges.fall[1])
      s_d.timer_control_and_ext_irq[irq_pkg::TC_IE1] = 1'b1;
    // ext 3 edge by polarity, or compare event
    if ((s_q.timer2_control[irq_pkg::T2_POL3] ? edges.rise[2] : edges.fall[2]) || compareEvent[0])
      s_d.reqFlags[irq_pkg::RQ_X3] = 1'b1;
    // ext 4-6 rising edges or compare events
    for (int i = 1; i < 4; i++)
      if (edges.rise[2 + i] || compareEvent[i])
        s_d.reqFlags[irq_pkg::RQ_X3 + i] = 1'b1;
    // machine cycle phase counter; flags frozen once per cycle
    s_d.phase = (s_q.phase == irq_pkg::MC_LAST) ? 4'h0 : s_q.phase + 4'h1;
    if (s_q.phase == irq_pkg::SAMPLE_PHASE)
      s_d.sampled = rawFlag;
    // flag and own enable and global enable
    s_d.request = s_q.sampled & vecEn & {irq_pkg::NVEC{s_q.ienFirst[irq_pkg::EN_GLOBAL]}};
    // wake on a low level of either pin while powered down
    s_d.wakeMeta = {alternateReceivePin, 1'b0};
    s_d.wakeSync = s_q.wakeMeta;
    s_d.wake = powerDown && (!edges.level[0] || !s_q.wakeSync[1]);
    // read data latched at setup and held through the access phase
    if (apbRd)
    begin
      case (paddr)
        irq_pkg::ADDR_IEN_FIRST: s_d.rdata = {24'h000000, s_q.ienFirst};
        irq_pkg::ADDR_IEN_SECOND: s_d.rdata = {24'h000000, s_q.ienSecond};
        irq_pkg::ADDR_REQ_FLAGS: s_d.rdata = {24'h000000, s_q.reqFlags};
        irq_pkg::ADDR_TIMER_CONTROL_AND_EXT_IRQ: s_d.rdata = {24'h000000, s_q.timer_control_and_ext_irq};
        irq_pkg::ADDR_TIMER2_CONTROL: s_d.rdata = {24'h000000, s_q.timer2_control};
        irq_pkg::ADDR_PRIO_LOW: s_d.rdata = {26'h0000000, s_q.prioLow};
        irq_pkg::ADDR_PRIO_HIGH: s_d.rdata = {26'h0000000, s_q.prioHigh};
        irq_pkg::ADDR_MISC: s_d.rdata = {20'h00000, s_q.request};
        default: s_d.rdata = '0;
      endcase
    end
    else if (!(psel && penable))
      s_d.rdata = '0;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    // every enable and priority bit clears at reset
    if (!nrst)
    begin
      s_q <= '0;
      s_q.wakeMeta <= 2'h3;
      s_q.wakeSync <= 2'h3;
    end
    else
      s_q <= s_d;
  end

  logic [3:0] outVec;
  logic outValid;
  logic [1:0] outLevel;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      outValid <= 1'b0;
      outVec <= 4'h0;
      outLevel <= 2'h0;
    end
    else
    begin
      outValid <= selValid;
      outVec <= selVector;
      outLevel <= selLevel;
    end
  end
  assign irqValid = outValid;
  assign irqVector = outVec;
  assign irqLevel = outLevel;
  assign irqRequest = s_q.request;
  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign timer2Reload = s_q.reload;
  assign wakeUp = s_q.wake;
endmodule : irq_request_ctrl

// [tb/irq_request_asserts.sv]
// assertion checker for the interrupt request block, bound to its top module
`timescale 1ns/10ps
module irq_request_asserts (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] irqRequest,
  input wire logic irqValid,
  input wire logic [3:0] irqVector,
  input wire logic timer2ReloadEdge,
  input wire logic timer2Reload,
  input wire logic powerDown,
  input wire logic wakeUp
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held over one cycle");
  a_one_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
    else $error("refused read returned data");
  a_idle_data: assert property (!psel && !$past(psel) |-> prdata == 32'h00000000)
    else $error("read data left standing");
  a_reset_quiet: assert property ($rose(nrst) |-> irqRequest == 12'h000 && !irqValid)
    else $error("request active after reset");
  a_valid_follows: assert property (irqValid == ($past(irqRequest, 2) != 12'h000))
    else $error("valid does not follow requests");
  a_vector_pending: assert property (irqValid |-> (($past(irqRequest, 2) >> irqVector) & 12'h001) != 12'h000)
    else $error("winning vector not pending");
  a_reload_follows: assert property (timer2ReloadEdge |=> timer2Reload)
    else $error("reload not passed on");
  a_wake_gated: assert property (!$past(powerDown) |-> !wakeUp)
    else $error("wake outside power-down");
endmodule : irq_request_asserts

bind irq_request_ctrl irq_request_asserts u_chk (
  .mclk(mclk),
  .nrst(nrst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .irqRequest(irqRequest),
  .irqValid(irqValid),
  .irqVector(irqVector),
  .timer2ReloadEdge(timer2ReloadEdge),
  .timer2Reload(timer2Reload),
  .powerDown(powerDown),
  .wakeUp(wakeUp)
);

// [tb/irq_cpu_model.sv]
// cpu-side partner: vectors to the winning request after a set delay
`timescale 1ns/10ps
module irq_cpu_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ackOn,
  input wire logic [3:0] ackDelay,
  input wire logic irqValid,
  input wire logic [3:0] irqVector,
  output logic vectorAck,
  output logic [3:0] vectorAckNum
);
  logic [5:0] holdQ;
  logic [3:0] delayQ;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      holdQ <= 6'h00;
      delayQ <= 4'h0;
      vectorAck <= 1'b0;
      vectorAckNum <= 4'h0;
    end
    else
    begin
      vectorAck <= 1'b0;
      // number is noise outside an acknowledge, so the block cannot lean on it
      vectorAckNum <= ~vectorAckNum;
      if (holdQ != 6'h00)
        holdQ <= holdQ - 6'h01;
      else if (ackOn && irqValid && delayQ == ackDelay)
      begin
        // one vector call per service; the hold stands for the routine
        vectorAck <= 1'b1;
        vectorAckNum <= irqVector;
        holdQ <= 6'h28;
        delayQ <= 4'h0;
      end
      else if (ackOn && irqValid)
        delayQ <= delayQ + 4'h1;
    end
  end
endmodule : irq_cpu_model

// [tb/irq_request_ctrl_bench.sv]
// self-checking bench for the interrupt request block
`timescale 1ns/10ps
module irq_request_ctrl_bench;
  logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [5:0] extPins = 6'h3F;
  logic alternateReceivePin = 1'b1, powerDown = 1'b0, ackOn = 1'b0;
  logic timer0Overflow = 1'b0, timer2Overflow = 1'b0, timer2ReloadEdge = 1'b0;
  logic converterDone = 1'b0, timer1Overflow = 1'b0, serialIrq = 1'b0, busCtrlIrq = 1'b0;
  logic [3:0] compareEvent = 4'h0, ackDelay = 4'h0, irqVector, vectorAckNum;
  logic [31:0] prdata;
  logic [11:0] irqRequest;
  logic [1:0] irqLevel;
  logic pready, pslverr, irqValid, timer2Reload, wakeUp, vectorAck;
  int miscompares = 0;
  int checks = 0;
  always #50 mclk = ~mclk;
  irq_request_ctrl u_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extPins(extPins), .alternateReceivePin(alternateReceivePin),
    .timer0Overflow(timer0Overflow), .timer1Overflow(timer1Overflow),
    .timer2Overflow(timer2Overflow), .timer2ReloadEdge(timer2ReloadEdge),
    .compareEvent(compareEvent), .serialIrq(serialIrq), .converterDone(converterDone),
    .busCtrlIrq(busCtrlIrq), .powerDown(powerDown), .vectorAck(vectorAck),
    .vectorAckNum(vectorAckNum), .irqValid(irqValid), .irqVector(irqVector),
    .irqLevel(irqLevel), .irqRequest(irqRequest), .timer2Reload(timer2Reload),
    .wakeUp(wakeUp));
  irq_cpu_model u_cpu (.mclk(mclk), .nrst(nrst), .ackOn(ackOn), .ackDelay(ackDelay),
    .irqValid(irqValid), .irqVector(irqVector), .vectorAck(vectorAck),
    .vectorAckNum(vectorAckNum));
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle
  function automatic logic [31:0] bitOf(input int i);
    return 32'h00000001 << i;
  endfunction : bitOf
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    idle(1);
    penable <= 1'b1;
    n = 0;
    do
    begin
      // look between edges, where the answer has settled
      @(negedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h00000001);
    q = prdata;
    e = pslverr;
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next setup never lands in the release time step
    idle(1);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask : rd
  // bound covers an ack hold, the sampling phase and the register stage
  task automatic waitReq(input int v, input logic exp);
    int n;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (irqRequest[v] !== exp && n < 100);
    chk({31'h0, irqRequest[v]}, {31'h0, exp});
    @(posedge mclk);
  endtask : waitReq
  task automatic clr(input int v);
    ackOn <= 1'b1;
    waitReq(v, 1'b0);
    ackOn <= 1'b0;
  endtask : clr
  task automatic t_regs();
    nrst <= 1'b0;
    idle(4);
    nrst <= 1'b1;
    idle(1);
    rd(irq_pkg::ADDR_IEN_FIRST, 32'h0, 1'b0);
    rd(irq_pkg::ADDR_IEN_SECOND, 32'h0, 1'b0);
    wr(irq_pkg::ADDR_PRIO_HIGH, 32'hFF);
    rd(irq_pkg::ADDR_PRIO_HIGH, 32'h3F, 1'b0);
    rd(12'h004, 32'h0, 1'b1);
  endtask : t_regs
  task automatic t_timer0();
    timer0Overflow <= 1'b1;
    converterDone <= 1'b1;
    idle(1);
    timer0Overflow <= 1'b0;
    converterDone <= 1'b0;
    idle(30);
    waitReq(irq_pkg::V_T0, 1'b0);
    wr(irq_pkg::ADDR_IEN_FIRST, bitOf(irq_pkg::EN_T0));
    idle(30);
    waitReq(irq_pkg::V_T0, 1'b0);
    wr(irq_pkg::ADDR_IEN_FIRST, bitOf(irq_pkg::EN_T0) | bitOf(irq_pkg::EN_GLOBAL));
    waitReq(irq_pkg::V_T0, 1'b1);
    idle(30);
    waitReq(irq_pkg::V_CONV, 1'b0);
    chk({28'h0, irqVector}, irq_pkg::V_T0);
    chk({30'h0, irqLevel}, 32'h2);
    clr(irq_pkg::V_T0);
  endtask : t_timer0
  task automatic t_swi();
    ackDelay <= 4'h7;
    wr(irq_pkg::ADDR_REQ_FLAGS, bitOf(irq_pkg::RQ_SWI));
    idle(30);
    waitReq(irq_pkg::V_BUS, 1'b0);
    wr(irq_pkg::ADDR_IEN_SECOND, bitOf(irq_pkg::EN_BUS));
    waitReq(irq_pkg::V_BUS, 1'b1);
    clr(irq_pkg::V_BUS);
  endtask : t_swi
  task automatic t_ext0();
    wr(irq_pkg::ADDR_IEN_FIRST, bitOf(irq_pkg::EN_X0) | bitOf(irq_pkg::EN_GLOBAL));
    wr(irq_pkg::ADDR_TIMER_CONTROL_AND_EXT_IRQ, 32'h0);
    extPins[0] <= 1'b0;
    waitReq(irq_pkg::V_X0, 1'b1);
    extPins[0] <= 1'b1;
    waitReq(irq_pkg::V_X0, 1'b0);
    wr(irq_pkg::ADDR_TIMER_CONTROL_AND_EXT_IRQ, bitOf(irq_pkg::TC_IT0));
    extPins[0] <= 1'b0;
    idle(3);
    extPins[0] <= 1'b1;
    waitReq(irq_pkg::V_X0, 1'b1);
    idle(30);
    waitReq(irq_pkg::V_X0, 1'b1);
    clr(irq_pkg::V_X0);
  endtask : t_ext0
  task automatic t_ext3();
    int vec [4];
    vec = '{irq_pkg::V_X3, irq_pkg::V_X4, irq_pkg::V_X5, irq_pkg::V_X6};
    wr(irq_pkg::ADDR_IEN_SECOND, 32'h3C);
    wr(irq_pkg::ADDR_TIMER2_CONTROL, bitOf(irq_pkg::T2_POL3));
    extPins[2] <= 1'b0;
    idle(30);
    waitReq(irq_pkg::V_X3, 1'b0);
    extPins[2] <= 1'b1;
    waitReq(irq_pkg::V_X3, 1'b1);
    clr(irq_pkg::V_X3);
    for (int i = 0; i < 4; i++)
    begin
      compareEvent <= 4'(1 << i);
      idle(1);
      compareEvent <= 4'h0;
      waitReq(vec[i], 1'b1);
      clr(vec[i]);
    end
    extPins[3] <= 1'b0;
    idle(30);
    waitReq(irq_pkg::V_X4, 1'b0);
    extPins[3] <= 1'b1;
    waitReq(irq_pkg::V_X4, 1'b1);
    clr(irq_pkg::V_X4);
  endtask : t_ext3
  task automatic t_timer2();
    wr(irq_pkg::ADDR_IEN_FIRST, bitOf(irq_pkg::EN_T2) | bitOf(irq_pkg::EN_GLOBAL));
    timer2ReloadEdge <= 1'b1;
    idle(1);
    timer2ReloadEdge <= 1'b0;
    @(negedge mclk);
    chk({31'h0, timer2Reload}, 32'h1);
    @(posedge mclk);
    timer2Overflow <= 1'b1;
    idle(1);
    timer2Overflow <= 1'b0;
    waitReq(irq_pkg::V_T2, 1'b1);
    ackOn <= 1'b1;
    idle(60);
    waitReq(irq_pkg::V_T2, 1'b1);
    ackOn <= 1'b0;
    wr(irq_pkg::ADDR_TIMER2_CONTROL, 32'h0);
    waitReq(irq_pkg::V_T2, 1'b0);
  endtask : t_timer2
  task automatic t_wake();
    int n;
    powerDown <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      if (i == 0)
        alternateReceivePin <= 1'b0;
      else
        extPins[0] <= 1'b0;
      n = 0;
      while (wakeUp !== 1'b1 && n < 10)
      begin
        idle(1);
        n++;
      end
      chk({31'h0, wakeUp}, 32'h1);
      alternateReceivePin <= 1'b1;
      extPins[0] <= 1'b1;
      idle(6);
      chk({31'h0, wakeUp}, 32'h0);
    end
    powerDown <= 1'b0;
  endtask : t_wake
  initial
  begin
    t_regs();
    t_timer0();
    t_swi();
    t_ext0();
    t_ext3();
    t_timer2();
    t_wake();
    t_regs();
    conclude();
  end
  initial
  begin
    #2000000;
    miscompares++;
    conclude();
  end
endmodule : irq_request_ctrl_bench
